/* bit_sync.sv */
`timescale 1ns/10ps
// two-stage synchroniser for asynchronous pin levels
module bit_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_syncOut;

   // first stage feeds only the second
   always_comb begin
      next_stage1  = pinIn;
      next_syncOut = stage1;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stage1  <= '0;
         syncOut <= '0;
      end else begin
         stage1  <= next_stage1;
         syncOut <= next_syncOut;
      end
   end
endmodule : bit_sync

/* bus_partner.sv */
`timescale 1ns/10ps
// far-side bus logic: drives a bus only while the device floats it
module bus_partner (
   input  wire xcvr_pkg::bus_t aOut,
   input  wire logic           aOutEn_b,
   input  wire xcvr_pkg::bus_t bOut,
   input  wire logic           bOutEn_b,
   input  wire xcvr_pkg::bus_t aVal,
   input  wire xcvr_pkg::bus_t bVal,
   output xcvr_pkg::bus_t      aIn,
   output xcvr_pkg::bus_t      bIn
);
   import xcvr_pkg::*;
   // wire level of each bus: exactly one driver at a time
   assign aIn = aOutEn_b ? aVal : aOut;
   assign bIn = bOutEn_b ? bVal : bOut;
endmodule : bus_partner

/* log_fifo.sv */
`timescale 1ns/10ps
// flip-flop fifo with valid/ready on both sides
module log_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 32
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   log_fifo_if.store port
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic [PW:0]   count, next_count;
   logic          doPush, doPop;

   // honest full and empty from the fill count
   always_comb begin
      port.inReady  = (count != (PW+1)'(DEPTH));
      port.outValid = (count != '0);
      port.outData  = mem[rdPtr];
      doPush        = port.inValid && port.inReady;
      doPop         = port.outValid && port.outReady;
      next_wrPtr    = doPush ? wrPtr + 1'b1 : wrPtr;
      next_rdPtr    = doPop ? rdPtr + 1'b1 : rdPtr;
      next_count    = count + (PW+1)'(doPush) - (PW+1)'(doPop);
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
      end
   end

   // storage carries no reset
   always_ff @(posedge clk_sys) begin
      if (doPush) begin
         mem[wrPtr] <= port.inData;
      end
   end
endmodule : log_fifo

/* log_fifo_if.sv */
`timescale 1ns/10ps
// carries capture words from the transceiver into the log buffer
interface log_fifo_if #(parameter int W = 9);
   logic [W-1:0] inData;
   logic         inValid;
   logic         inReady;
   logic [W-1:0] outData;
   logic         outValid;
   logic         outReady;

   modport user  (output inData, inValid, outReady,
                  input  inReady, outData, outValid);
   modport store (input  inData, inValid, outReady,
                  output inReady, outData, outValid);
endinterface : log_fifo_if

/* octal_xcvr.sv */
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
// registered octal bus transceiver with axi4-lite status and capture log
module octal_xcvr #(
   parameter bit INVERT_VARIANT = 1'b0
) (
   input  wire logic           clk_sys,
   input  wire logic           rst_b,
   input  wire xcvr_pkg::bus_t aIn,
   output xcvr_pkg::bus_t      aOut,
   output logic                aOutEn_b,
   input  wire xcvr_pkg::bus_t bIn,
   output xcvr_pkg::bus_t      bOut,
   output logic                bOutEn_b,
   input  wire logic           aToBDriveEnable,
   input  wire logic           bToADriveEnable_b,
   input  wire logic           aCaptureClock,
   input  wire logic           bCaptureClock,
   input  wire logic           bSideSourceSelect,
   input  wire logic           aSideSourceSelect,
   input  wire xcvr_pkg::addr_t awaddr,
   input  wire logic           awvalid,
   output logic                awready,
   input  wire xcvr_pkg::word_t wdata,
   input  wire logic [3:0]     wstrb,
   input  wire logic           wvalid,
   output logic                wready,
   output xcvr_pkg::resp_t     bresp,
   output logic                bvalid,
   input  wire logic           bready,
   input  wire xcvr_pkg::addr_t araddr,
   input  wire logic           arvalid,
   output logic                arready,
   output xcvr_pkg::word_t     rdata,
   output xcvr_pkg::resp_t     rresp,
   output logic                rvalid,
   input  wire logic           rready
);
   import xcvr_pkg::*;

   logic [SYNC_W-1:0] syncBus;
   bus_t syncA, syncB;
   logic syncGab, syncGbaN, syncCab, syncCba, syncSab, syncSba;
   logic syncGbaOn;
   logic cabPrev, cbaPrev, next_cabPrev, next_cbaPrev;
   logic aEdge, bEdge;
   bus_t storeAB, storeBA, next_storeAB, next_storeBA;
   bus_t invMask, next_aOut, next_bOut;
   logic next_aOutEn_b, next_bOutEn_b;
   logic [1:0] ctrl, next_ctrl;
   logic logPend, next_logPend, overflow, next_overflow;
   logic [LOG_W-1:0] logWord, next_logWord;
   logic awHeld, wHeld, next_awHeld, next_wHeld;
   addr_t awAddrQ, next_awAddrQ;
   word_t wDataQ, next_wDataQ;
   logic [3:0] wStrbQ, next_wStrbQ;
   logic next_awready, next_wready, next_bvalid, next_arready;
   logic next_rvalid;
   resp_t next_bresp, next_rresp;
   word_t next_rdata, statusWord;
   logic doWrite, arTake, popLog;

   log_fifo_if #(.W(LOG_W)) logIf ();

   // all bus and control pins cross into clk_sys through two flops; the active-low
   // enable is flipped first so a reset synchroniser reads as float
   bit_sync #(.W(SYNC_W)) pinSync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .pinIn   ({aIn, bIn, aToBDriveEnable, ~bToADriveEnable_b,
                 aCaptureClock, bCaptureClock, bSideSourceSelect,
                 aSideSourceSelect}),
      .syncOut (syncBus)
   );

   assign {syncA, syncB, syncGab, syncGbaOn, syncCab, syncCba, syncSab,
           syncSba} = syncBus;
   assign syncGbaN = ~syncGbaOn; // R04

   log_fifo #(.W(LOG_W), .DEPTH(FIFO_DEPTH)) logBuf (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .port    (logIf.store)
   );

   // capture edges and data paths
   always_comb begin
      next_cabPrev  = syncCab;
      next_cbaPrev  = syncCba;
      aEdge         = syncCab && !cabPrev;
      bEdge         = syncCba && !cbaPrev;
      next_storeAB  = aEdge ? syncA : storeAB; // R06 R12
      next_storeBA  = bEdge ? syncB : storeBA; // R09 R12
      invMask       = {DATA_W{ctrl[CTRL_INV_BIT]}}; // R10 R11
      next_bOut     = (syncSab ? storeAB : syncA) ^ invMask; // R07 R08
      next_aOut     = (syncSba ? storeBA : syncB) ^ invMask; // R09
      next_bOutEn_b = !syncGab; // R01 R02 R05
      next_aOutEn_b = syncGbaN; // R03 R04 R05
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cabPrev  <= 1'b0;
         cbaPrev  <= 1'b0;
         aOut     <= '0;
         bOut     <= '0;
         aOutEn_b <= 1'b1;
         bOutEn_b <= 1'b1;
      end else begin
         cabPrev  <= next_cabPrev;
         cbaPrev  <= next_cbaPrev;
         aOut     <= next_aOut;
         bOut     <= next_bOut;
         aOutEn_b <= next_aOutEn_b;
         bOutEn_b <= next_bOutEn_b;
      end
   end

   // storage registers have no reset
   always_ff @(posedge clk_sys) begin
      storeAB <= next_storeAB;
      storeBA <= next_storeBA;
   end

   // capture log: one pending word waits for fifo space
   always_comb begin
      next_logPend  = logPend;
      next_logWord  = logWord;
      next_overflow = overflow;
      if (logPend && logIf.inReady) begin
         next_logPend = 1'b0;
      end
      if (doWrite && awAddrQ == STATUS_OFS && wStrbQ[2]
          && wDataQ[ST_OVF_BIT]) begin
         next_overflow = 1'b0;
      end
      if (ctrl[CTRL_LOG_BIT] && (aEdge || bEdge)) begin
         if (next_logPend || (aEdge && bEdge)) begin
            next_overflow = 1'b1; // set wins over clear
         end
         if (!next_logPend) begin
            next_logPend = 1'b1;
            next_logWord = aEdge ? {1'b0, syncA} : {1'b1, syncB};
         end
      end
      logIf.inValid  = logPend;
      logIf.inData   = logWord;
      logIf.outReady = popLog;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         logPend  <= 1'b0;
         logWord  <= '0;
         overflow <= 1'b0;
      end else begin
         logPend  <= next_logPend;
         logWord  <= next_logWord;
         overflow <= next_overflow;
      end
   end

   // axi4-lite slave: address and data taken in either order
   always_comb begin
      next_awHeld  = awHeld || (awvalid && awready);
      next_wHeld   = wHeld || (wvalid && wready);
      next_awAddrQ = (awvalid && awready) ? awaddr : awAddrQ;
      next_wDataQ  = (wvalid && wready) ? wdata : wDataQ;
      next_wStrbQ  = (wvalid && wready) ? wstrb : wStrbQ;
      doWrite      = awHeld && wHeld && !bvalid;
      next_ctrl    = ctrl;
      next_bvalid  = bvalid && !bready;
      next_bresp   = bresp;
      if (doWrite) begin
         next_awHeld = 1'b0;
         next_wHeld  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = RESP_OKAY;
         if (awAddrQ == CTRL_OFS) begin
            if (wStrbQ[0]) begin
               next_ctrl = wDataQ[1:0];
            end
         end else if (awAddrQ != STATUS_OFS) begin
            next_bresp = RESP_SLVERR;
         end
      end
      next_awready = !next_awHeld && !next_bvalid;
      next_wready  = !next_wHeld && !next_bvalid;
   end

   // read side: one cycle from address to data
   always_comb begin
      statusWord = '0;
      statusWord[ST_AB_LSB +: DATA_W] = storeAB;
      statusWord[ST_BA_LSB +: DATA_W] = storeBA;
      statusWord[ST_AVAIL_BIT]        = logIf.outValid;
      statusWord[ST_OVF_BIT]          = overflow;
      statusWord[ST_FULL_BIT]         = !logIf.inReady;
      arTake       = arvalid && arready;
      popLog       = arTake && araddr == LOG_OFS && logIf.outValid;
      next_rvalid  = rvalid && !rready;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (arTake) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         case (araddr)
            CTRL_OFS:   next_rdata = {30'h0, ctrl};
            STATUS_OFS: next_rdata = statusWord;
            LOG_OFS:    next_rdata = {22'h0, logIf.outValid,
                                      logIf.outData};
            default: begin
               next_rdata = '0;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl    <= CTRL_RST | {1'b0, INVERT_VARIANT};
         awHeld  <= 1'b0;
         wHeld   <= 1'b0;
         awAddrQ <= '0;
         wDataQ  <= '0;
         wStrbQ  <= '0;
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else begin
         ctrl    <= next_ctrl;
         awHeld  <= next_awHeld;
         wHeld   <= next_wHeld;
         awAddrQ <= next_awAddrQ;
         wDataQ  <= next_wDataQ;
         wStrbQ  <= next_wStrbQ;
         awready <= next_awready;
         wready  <= next_wready;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         arready <= next_arready;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end
   end

   // checks on the transceiver paths
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   a_bdrive_on: assert property (syncGab |=> !bOutEn_b) // R01
      else $error("B port not driven while enabled");
   a_bdrive_off: assert property (!syncGab |=> bOutEn_b) // R02
      else $error("B port driven while disabled");
   a_adrive_on: assert property (!syncGbaN |=> !aOutEn_b) // R03
      else $error("A port not driven while enabled");
   a_adrive_off: assert property (syncGbaN |=> aOutEn_b) // R04
      else $error("A port driven while disabled");
   a_enable_indep: assert property ( // R05
      $stable(syncGab) && $changed(syncGbaN) |=> $stable(bOutEn_b))
      else $error("B enable moved with A enable");
   a_capture_ab: assert property ( // R06
      aEdge |=> storeAB == $past(syncA))
      else $error("A data not captured on edge");
   a_stored_b: assert property ( // R07
      syncSab |=> bOut == ($past(storeAB) ^ $past(invMask)))
      else $error("B output not from stored value");
   a_live_b: assert property ( // R08
      !syncSab |=> bOut == ($past(syncA) ^ $past(invMask)))
      else $error("B output not following live A");
   a_mirror_ba: assert property ( // R09
      bEdge ##1 syncSba |=> aOut == ($past(storeBA) ^ $past(invMask)))
      else $error("A output not from stored B value");
   a_invert_path: assert property ( // R10
      ctrl[CTRL_INV_BIT] && !syncSba |=> aOut == ~$past(syncB))
      else $error("inverting path not complemented");
   a_true_path: assert property ( // R11
      !ctrl[CTRL_INV_BIT] && syncSab |=> bOut == $past(storeAB))
      else $error("non-inverting path changed polarity");
   a_store_hold: assert property ( // R12
      !aEdge && !bEdge |=> $stable(storeAB) && $stable(storeBA))
      else $error("stored value moved without edge");

   c_stored_out: cover property (syncSab && syncGab ##1 aEdge);
   c_log_full: cover property (!logIf.inReady);
   c_overflow: cover property ($rose(overflow));
   c_log_pop: cover property (popLog);
endmodule : octal_xcvr

/* octal_xcvr_bench.sv */
`timescale 1ns/10ps
// pin and axi4-lite tests of the octal transceiver
module octal_xcvr_bench;
   import xcvr_pkg::*;
   logic       clk_sys, rst_b, aOutEn_b, bOutEn_b;
   logic       aToBDriveEnable, bToADriveEnable_b;
   logic       aCaptureClock, bCaptureClock;
   logic       bSideSourceSelect, aSideSourceSelect;
   logic       awvalid, awready, wvalid, wready, bvalid, bready;
   logic       arvalid, arready, rvalid, rready;
   logic [3:0] wstrb;
   bus_t       aIn, aOut, bIn, bOut, aVal, bVal;
   addr_t      awaddr, araddr;
   word_t      wdata, rdata, rd;
   resp_t      bresp, rresp, rs;
   int         num_errors, checked;

   octal_xcvr #(.INVERT_VARIANT(1'b0)) dut_u (
      .clk_sys, .rst_b, .aIn, .aOut, .aOutEn_b, .bIn, .bOut, .bOutEn_b,
      .aToBDriveEnable, .bToADriveEnable_b, .aCaptureClock,
      .bCaptureClock, .bSideSourceSelect, .aSideSourceSelect,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready);

   bus_partner partner_u (
      .aOut, .aOutEn_b, .bOut, .bOutEn_b, .aVal, .bVal, .aIn, .bIn);

   // free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic end_of_test;
      if (num_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   task automatic check(input string name, input word_t exp,
                        input word_t got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // a bus turnaround needs six edges; eight leaves margin
   task automatic settle;
      repeat (8) @(posedge clk_sys);
   endtask : settle

   task automatic pulse(input logic forA);
      if (forA)
         aCaptureClock <= 1'b1;
      else
         bCaptureClock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      aCaptureClock <= 1'b0;
      bCaptureClock <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask : pulse

   task automatic axi_write(input addr_t ad, input word_t d,
                            output resp_t r);
      logic awDone, wDone;
      @(posedge clk_sys);
      awaddr  <= ad;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hf;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      awDone = 1'b0;
      wDone  = 1'b0;
      while (!(awDone && wDone)) begin
         @(posedge clk_sys);
         if (awvalid && awready === 1'b1) begin
            awDone = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            wDone = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge clk_sys);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input addr_t ad, output word_t d,
                           output resp_t r);
      @(posedge clk_sys);
      araddr  <= ad;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk_sys);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read

   // watchdog against a hung handshake
   initial begin
      #100000;
      num_errors++;
      end_of_test;
   end

   // main sequence
   initial begin
      num_errors = 0;
      checked = 0;
      rst_b = 1'b0;
      {aToBDriveEnable, aCaptureClock, bCaptureClock} = 3'h0;
      {bSideSourceSelect, aSideSourceSelect} = 2'h0;
      bToADriveEnable_b = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata, wstrb} = '0;
      aVal = 8'h00;
      bVal = 8'h00;
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      settle;
      check("aOutEn_b", 1, aOutEn_b);
      check("bOutEn_b", 1, bOutEn_b);
      axi_read(CTRL_OFS, rd, rs);
      check("ctrl", {30'h0, CTRL_RST}, rd);
      axi_read(8'h0c, rd, rs);
      check("unmapped rresp", RESP_SLVERR, rs);
      check("unmapped rdata", 0, rd);
      axi_write(8'h0c, 32'h0, rs);
      check("unmapped bresp", RESP_SLVERR, rs);
      axi_write(LOG_OFS, 32'h0, rs);
      check("log bresp", RESP_SLVERR, rs);
      // live a to b path, then a capture
      aVal <= 8'h55;
      aToBDriveEnable <= 1'b1;
      settle;
      check("bOut live", 8'h55, bOut);
      check("bOutEn_b", 0, bOutEn_b);
      check("aOutEn_b", 1, aOutEn_b);
      aVal <= 8'ha5;
      settle;
      pulse(1'b1);
      aVal <= 8'h3c;
      bSideSourceSelect <= 1'b1;
      settle;
      check("bOut stored", 8'ha5, bOut);
      axi_read(STATUS_OFS, rd, rs);
      check("status ab", 8'ha5, rd[ST_AB_LSB +: DATA_W]);
      check("log avail", 1, rd[ST_AVAIL_BIT]);
      axi_write(CTRL_OFS, 32'h3, rs);
      settle;
      check("bOut stored inv", 8'h5a, bOut);
      bSideSourceSelect <= 1'b0;
      settle;
      check("bOut live inv", 8'hc3, bOut);
      // b to a direction
      aToBDriveEnable <= 1'b0;
      bToADriveEnable_b <= 1'b0;
      bVal <= 8'h96;
      settle;
      check("bOutEn_b off", 1, bOutEn_b);
      check("aOutEn_b on", 0, aOutEn_b);
      check("aOut live inv", 8'h69, aOut);
      pulse(1'b0);
      bVal <= 8'h0f;
      aSideSourceSelect <= 1'b1;
      axi_write(CTRL_OFS, 32'h2, rs);
      settle;
      check("aOut stored", 8'h96, aOut);
      aSideSourceSelect <= 1'b0;
      settle;
      check("aOut live", 8'h0f, aOut);
      bToADriveEnable_b <= 1'b1;
      settle;
      check("aOutEn_b off", 1, aOutEn_b);
      axi_read(STATUS_OFS, rd, rs);
      check("status ba", 8'h96, rd[ST_BA_LSB +: DATA_W]);
      axi_read(LOG_OFS, rd, rs);
      check("log a", 32'h2a5, rd);
      axi_read(LOG_OFS, rd, rs);
      check("log b", 32'h396, rd);
      axi_read(LOG_OFS, rd, rs);
      check("log empty", 0, rd[LOG_VALID_BIT]);
      // fill the log past its depth while nobody reads
      for (int i = 0; i < FIFO_DEPTH + 2; i++) begin
         aVal <= bus_t'(i);
         repeat (2) @(posedge clk_sys);
         pulse(1'b1);
      end
      axi_read(STATUS_OFS, rd, rs);
      check("log full", 1, rd[ST_FULL_BIT]);
      check("overflow", 1, rd[ST_OVF_BIT]);
      for (int i = 0; i <= FIFO_DEPTH; i++) begin
         axi_read(LOG_OFS, rd, rs);
         check("log entry", 32'h200 | word_t'(i), rd);
      end
      axi_read(LOG_OFS, rd, rs);
      check("log drained", 0, rd[LOG_VALID_BIT]);
      axi_write(STATUS_OFS, 32'h1 << ST_OVF_BIT, rs);
      axi_read(STATUS_OFS, rd, rs);
      check("overflow clear", 0, rd[ST_OVF_BIT]);
      end_of_test;
   end
endmodule : octal_xcvr_bench

/* xcvr_pkg.sv */
// Functional notes
// R01: drive enable high drives all B outputs
// R02: drive enable low floats the B outputs
// R03: active-low enable low drives A outputs
// R04: active-low enable high floats A outputs
// R05: each port follows only its own enable
// R06: A capture clock rise stores A bus
// R07: B select high offers stored A data
// R08: B select low offers live A data
// R09: B-to-A direction mirrors A-to-B direction
// R10: inverting variant complements both paths
// R11: non-inverting variant keeps polarity on both paths
// R12: stored value holds until own capture edge
// R13: outside logic avoids live loops driving both buses
package xcvr_pkg;
   localparam int DATA_W     = 8;
   localparam int FIFO_DEPTH = 32;
   localparam int LOG_W      = DATA_W + 1;
   localparam int ADDR_W     = 8;
   localparam int SYNC_W     = 2 * DATA_W + 6;

   typedef logic [DATA_W-1:0] bus_t;
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [31:0]       word_t;
   typedef logic [1:0]        resp_t;

   // register byte addresses
   localparam addr_t CTRL_OFS   = 8'h00;
   localparam addr_t STATUS_OFS = 8'h04;
   localparam addr_t LOG_OFS    = 8'h08;

   // control fields and reset value
   localparam int         CTRL_INV_BIT = 0;
   localparam int         CTRL_LOG_BIT = 1;
   localparam logic [1:0] CTRL_RST     = 2'h2;

   // status fields
   localparam int ST_AB_LSB    = 0;
   localparam int ST_BA_LSB    = 8;
   localparam int ST_AVAIL_BIT = 16;
   localparam int ST_OVF_BIT   = 17;
   localparam int ST_FULL_BIT  = 18;

   // log word fields
   localparam int LOG_DIR_BIT   = 8;
   localparam int LOG_VALID_BIT = 9;

   localparam resp_t RESP_OKAY   = 2'h0;
   localparam resp_t RESP_SLVERR = 2'h2;
endpackage : xcvr_pkg
